// *** logic/dbmc_lock_timer.sv ***
`timescale 1ns/1ps
`include "dbmc_params.svh"
module dbmc_lock_timer #(
  parameter int unsigned LOCK_CYCLES = `DBMC_LOCK_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  // control
  input wire logic i_start,
  input wire logic i_stop,
  // status
  output logic o_locked
);
  typedef struct packed {
    logic [8:0] cnt;
    logic locked;
  } dbmc_tmr_t;
  dbmc_tmr_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    if (i_stop) begin
      s_d.locked = 1'b0;
      s_d.cnt = 9'h000;
    end else if (i_start) begin
      s_d.locked = 1'b0;
      s_d.cnt = 9'(LOCK_CYCLES);
    end else if (s_q.cnt != 9'h000) begin
      s_d.cnt = s_q.cnt - 9'h001;
      if (s_q.cnt == 9'h001) s_d.locked = 1'b1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) s_q <= '0;
    else if (i_ce) s_q <= s_d;
  end
  assign o_locked = s_q.locked;
endmodule : dbmc_lock_timer

// *** logic/dbmc_params.svh ***
`ifndef DBMC_PARAMS_SVH
`define DBMC_PARAMS_SVH
// register byte offsets
`define DBMC_OFF_BASE_MODE   8'h00
`define DBMC_OFF_EXT_MODE    8'h04
`define DBMC_OFF_CMD         8'h08
`define DBMC_OFF_STATUS      8'h0C
`define DBMC_OFF_SEQ         8'h10
// base mode fields
`define DBMC_BL_LSB          0
`define DBMC_BT_BIT          3
`define DBMC_CL_LSB          4
`define DBMC_DLL_RST_BIT     8
// extended mode fields
`define DBMC_DLL_DIS_BIT     0
`define DBMC_HALF_DRV_BIT    1
`define DBMC_FET_SW_BIT      2
// command register fields
`define DBMC_CMD_CS_N        0
`define DBMC_CMD_RAS_N       1
`define DBMC_CMD_CAS_N       2
`define DBMC_CMD_WE_N        3
`define DBMC_CMD_BA_LSB      4
`define DBMC_CMD_ADDR_LSB    8
`define DBMC_CMD_READ_BIT    24
`define DBMC_CMD_WRITE_BIT   25
`define DBMC_CMD_SR_ENTER    26
`define DBMC_CMD_SR_EXIT     27
// status fields
`define DBMC_ST_LOCKED       0
`define DBMC_ST_LOAD_BUSY    1
`define DBMC_ST_BURST        2
`define DBMC_ST_SELF_REF     3
`define DBMC_ST_DATA_LSB     8
// reset values
`define DBMC_BASE_RST        13'h0000
`define DBMC_EXT_RST         13'h0000
// timing
`define DBMC_LOCK_CYCLES     200
`define DBMC_LOAD_CYCLES     2
// codes
`define DBMC_BL_2            3'h1
`define DBMC_BL_4            3'h2
`define DBMC_BL_8            3'h3
`define DBMC_CL_2            3'h2
`define DBMC_CL_3            3'h3
`define DBMC_CL_2P5          3'h6
`endif

// *** logic/dbmc_pkg.sv ***
package dbmc_pkg;
  typedef enum logic [3:0] {
    DBMC_IDLE  = 4'h1,
    DBMC_LOAD  = 4'h2,
    DBMC_WAIT  = 4'h4,
    DBMC_BURST = 4'h8
  } dbmc_state_t;
  typedef logic [1:0] dbmc_resp_t;
endpackage : dbmc_pkg

// *** logic/dbmc_top.sv ***
`timescale 1ns/1ps
`include "dbmc_params.svh"
module dbmc_top #(
  parameter int unsigned LOCK_CYCLES = `DBMC_LOCK_CYCLES
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  // axi4-lite write address
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  // axi4-lite write data
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // axi4-lite write response
  output dbmc_pkg::dbmc_resp_t o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read address
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  // axi4-lite read data
  output logic [31:0] o_rdata,
  output dbmc_pkg::dbmc_resp_t o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // burst column stream
  output logic [2:0] o_col_offset,
  output logic o_col_valid,
  output logic o_col_write,
  output logic o_col_last,
  output logic o_read_launch,
  output logic o_launch_falling,
  // mode state
  output logic o_dll_locked,
  output logic o_half_drive
);
  import dbmc_pkg::*;

  typedef struct packed {
    dbmc_state_t st;
    logic [12:0] base_mode;
    logic [12:0] ext_mode;
    logic self_ref;
    logic [1:0] load_cnt;
    logic [2:0] start_off;
    logic [2:0] beat;
    logic [2:0] last_beat;
    logic burst_wr;
    logic [2:0] lat_cnt;
    logic lat_active;
    logic lat_half;
    logic [2:0] col_offset;
    logic col_valid;
    logic col_write;
    logic col_last;
    logic read_launch;
    logic launch_falling;
    logic half_drive;
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } dbmc_top_state_t;

  dbmc_top_state_t s_q, s_d;
  logic dll_locked;
  logic dll_start;
  logic dll_stop;

  // beats in a burst minus one for a length code; reserved codes fall back to two
  function automatic logic [2:0] last_of(input logic [2:0] bl);
    if (bl == `DBMC_BL_8) last_of = 3'h7;
    else if (bl == `DBMC_BL_4) last_of = 3'h3;
    else last_of = 3'h1;
  endfunction : last_of

  // k-th offset inside the block; mask keeps the wrap inside it
  function automatic logic [2:0] col_of(input logic [2:0] start, input logic [2:0] k,
                                         input logic [2:0] lastb, input logic ilv);
    logic [2:0] raw;
    raw = ilv ? (start ^ k) : 3'(start + k);
    col_of = raw & lastb;
  endfunction : col_of

  // whole cycles of read latency before the launch edge; 2.5 uses two plus a half
  function automatic logic [2:0] lat_of(input logic [2:0] cl);
    if (cl == `DBMC_CL_3) lat_of = 3'h3;
    else lat_of = 3'h2;
  endfunction : lat_of

  logic wr_go;
  logic cmd_hit;
  logic mode_cmd;
  logic [31:0] cmd;
  logic [31:0] rd_word;

  always_comb begin
    s_d = s_q;
    dll_start = 1'b0;
    dll_stop = 1'b0;
    wr_go = 1'b0;
    cmd_hit = 1'b0;
    mode_cmd = 1'b0;
    cmd = s_q.wdata;
    rd_word = 32'h0000_0000;
    s_d.col_valid = 1'b0;
    s_d.col_last = 1'b0;
    s_d.read_launch = 1'b0;
    s_d.launch_falling = 1'b0;

    // write channels, taken in either order
    if (i_awvalid && s_q.awready) begin
      s_d.awaddr = i_awaddr;
      s_d.aw_held = 1'b1;
      s_d.awready = 1'b0;
    end
    if (i_wvalid && s_q.wready) begin
      s_d.wdata = i_wdata;
      s_d.wstrb = i_wstrb;
      s_d.w_held = 1'b1;
      s_d.wready = 1'b0;
    end
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
      wr_go = 1'b1;
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = 2'h0;
      if (s_q.awaddr == `DBMC_OFF_CMD) begin
        cmd_hit = (s_q.st == DBMC_IDLE);
      end else if (s_q.awaddr == `DBMC_OFF_BASE_MODE) begin
        s_d.bresp = 2'h0;
      end else if (s_q.awaddr == `DBMC_OFF_EXT_MODE) begin
        s_d.bresp = 2'h0;
      end else if (s_q.awaddr == `DBMC_OFF_STATUS || s_q.awaddr == `DBMC_OFF_SEQ) begin
        s_d.bresp = 2'h0;
      end else begin
        s_d.bresp = 2'h2;
      end
    end
    if (s_q.bvalid && i_bready) begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end

    // commands arrive through the command register; busy state drops them
    mode_cmd = cmd_hit && !cmd[`DBMC_CMD_CS_N] && !cmd[`DBMC_CMD_RAS_N]
               && !cmd[`DBMC_CMD_CAS_N] && !cmd[`DBMC_CMD_WE_N];
    if (mode_cmd) begin
      s_d.st = DBMC_LOAD;
      s_d.load_cnt = 2'(`DBMC_LOAD_CYCLES - 1);
      if (!cmd[`DBMC_CMD_BA_LSB]) begin
        s_d.base_mode = cmd[`DBMC_CMD_ADDR_LSB +: 13];
        if (cmd[`DBMC_CMD_ADDR_LSB + `DBMC_DLL_RST_BIT]) dll_start = 1'b1;
      end else if (!cmd[`DBMC_CMD_BA_LSB + 1]) begin
        s_d.ext_mode = cmd[`DBMC_CMD_ADDR_LSB +: 13];
        if (cmd[`DBMC_CMD_ADDR_LSB + `DBMC_DLL_DIS_BIT]) dll_stop = 1'b1;
        else if (s_q.ext_mode[`DBMC_DLL_DIS_BIT]) dll_start = 1'b1;
      end
    end else if (cmd_hit && cmd[`DBMC_CMD_SR_ENTER] && !s_q.self_ref) begin
      s_d.self_ref = 1'b1;
      dll_stop = 1'b1;
    end else if (cmd_hit && cmd[`DBMC_CMD_SR_EXIT] && s_q.self_ref) begin
      s_d.self_ref = 1'b0;
      if (!s_q.ext_mode[`DBMC_DLL_DIS_BIT]) dll_start = 1'b1;
    end else if (cmd_hit && !s_q.self_ref
                 && (cmd[`DBMC_CMD_READ_BIT] || cmd[`DBMC_CMD_WRITE_BIT])) begin
      // one length for both directions
      s_d.last_beat = last_of(s_q.base_mode[`DBMC_BL_LSB +: 3]);
      s_d.start_off = cmd[`DBMC_CMD_ADDR_LSB +: 3] & last_of(s_q.base_mode[2:0]);
      s_d.beat = 3'h0;
      s_d.burst_wr = cmd[`DBMC_CMD_WRITE_BIT];
      if (cmd[`DBMC_CMD_WRITE_BIT]) begin
        s_d.st = DBMC_BURST;
      end else begin
        s_d.st = DBMC_WAIT;
        s_d.lat_cnt = lat_of(s_q.base_mode[`DBMC_CL_LSB +: 3]);
        s_d.lat_half = (s_q.base_mode[`DBMC_CL_LSB +: 3] == `DBMC_CL_2P5);
      end
    end

    case (s_q.st)
      DBMC_LOAD: begin
        if (s_q.load_cnt == 2'h0) s_d.st = DBMC_IDLE;
        else s_d.load_cnt = s_q.load_cnt - 2'h1;
      end
      DBMC_WAIT: begin
        if (s_q.lat_cnt == 3'h1) begin
          // launch register rises on edge n plus m itself, so a falling flag means n plus m and a half
          s_d.read_launch = 1'b1;
          s_d.launch_falling = s_q.lat_half;
          s_d.st = DBMC_BURST;
        end else begin
          s_d.lat_cnt = s_q.lat_cnt - 3'h1;
        end
      end
      DBMC_BURST: begin
        s_d.col_valid = 1'b1;
        s_d.col_write = s_q.burst_wr;
        s_d.col_offset = col_of(s_q.start_off, s_q.beat, s_q.last_beat,
                                s_q.base_mode[`DBMC_BT_BIT]);
        s_d.col_last = (s_q.beat == s_q.last_beat);
        s_d.beat = s_q.beat + 3'h1;
        if (s_q.beat == s_q.last_beat) s_d.st = DBMC_IDLE;
      end
      default: ;
    endcase
    s_d.half_drive = s_d.ext_mode[`DBMC_HALF_DRV_BIT];

    // read channel
    if (i_arvalid && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rresp = 2'h0;
      if (i_araddr == `DBMC_OFF_BASE_MODE) begin
        rd_word = {19'h00000, s_q.base_mode};
      end else if (i_araddr == `DBMC_OFF_EXT_MODE) begin
        rd_word = {19'h00000, s_q.ext_mode};
      end else if (i_araddr == `DBMC_OFF_CMD) begin
        rd_word = s_q.wdata;
      end else if (i_araddr == `DBMC_OFF_STATUS) begin
        rd_word = {21'h000000, s_q.col_offset, 4'h0, s_q.self_ref,
                   (s_q.st == DBMC_BURST || s_q.st == DBMC_WAIT),
                   (s_q.st == DBMC_LOAD), dll_locked};
      end else if (i_araddr == `DBMC_OFF_SEQ) begin
        rd_word = {26'h0000000, s_q.last_beat, s_q.start_off};
      end else begin
        s_d.rresp = 2'h2;
      end
      s_d.rdata = rd_word;
    end
    if (s_q.rvalid && i_rready) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      s_q <= '0;
      s_q.st <= DBMC_IDLE;
      s_q.base_mode <= `DBMC_BASE_RST;
      s_q.ext_mode <= `DBMC_EXT_RST;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  dbmc_lock_timer #(
    .LOCK_CYCLES(LOCK_CYCLES)
  ) u_lock (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_start(dll_start),
    .i_stop(dll_stop),
    .o_locked(dll_locked)
  );

  assign o_awready = s_q.awready;
  assign o_wready = s_q.wready;
  assign o_bvalid = s_q.bvalid;
  assign o_bresp = s_q.bresp;
  assign o_arready = s_q.arready;
  assign o_rvalid = s_q.rvalid;
  assign o_rresp = s_q.rresp;
  assign o_rdata = s_q.rdata;
  assign o_col_offset = s_q.col_offset;
  assign o_col_valid = s_q.col_valid;
  assign o_col_write = s_q.col_write;
  assign o_col_last = s_q.col_last;
  assign o_read_launch = s_q.read_launch;
  assign o_launch_falling = s_q.launch_falling;
  assign o_half_drive = s_q.half_drive;
  assign o_dll_locked = dll_locked;

  sequence seq_burst_start;
    s_q.st != DBMC_BURST ##1 s_q.st == DBMC_BURST;
  endsequence
  chk_burst_len8: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_ce)
    (seq_burst_start ##0 (s_q.last_beat == 3'h7)) |-> ##7 s_q.st == DBMC_BURST)
    else $error("length eight burst ended early");
  chk_col_wrap: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_col_valid |-> ((o_col_offset & ~s_q.last_beat) == 3'h0))
    else $error("column offset left its block");
  chk_load_two: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_ce)
    $rose(s_q.st == DBMC_LOAD) |-> s_q.st == DBMC_LOAD [*2] ##1 s_q.st == DBMC_IDLE)
    else $error("mode load not two cycles");
  chk_sr_dll: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_ce)
    $rose(s_q.self_ref) |-> !dll_locked)
    else $error("dll still locked in self refresh");
  chk_half_drv: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_ce)
    o_half_drive == s_q.ext_mode[`DBMC_HALF_DRV_BIT])
    else $error("drive strength not following extended mode");
  chk_read_lat: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_ce)
    $rose(s_q.st == DBMC_WAIT) |-> ##[2:3] o_read_launch)
    else $error("read launch late");
  chk_half_launch: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_launch_falling |-> o_read_launch)
    else $error("falling launch without launch");
  chk_seq_step: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_ce)
    (o_col_valid && !o_col_last && !s_q.base_mode[`DBMC_BT_BIT] && s_q.st == DBMC_BURST)
    |=> o_col_offset == ((3'($past(o_col_offset) + 3'h1)) & s_q.last_beat))
    else $error("sequential step wrong");
endmodule : dbmc_top

// *** tb/dbmc_ctl_model.sv ***
`timescale 1ns/1ps
module dbmc_ctl_model (
  // clock and lock status
  input wire logic i_clk,
  input wire logic i_dll_locked,
  // write channels
  output logic [7:0] o_awaddr,
  output logic o_awvalid,
  input wire logic i_awready,
  output logic [31:0] o_wdata,
  output logic o_wvalid,
  input wire logic i_wready,
  input wire logic [1:0] i_bresp,
  input wire logic i_bvalid,
  output logic o_bready,
  // read channels
  output logic [7:0] o_araddr,
  output logic o_arvalid,
  input wire logic i_arready,
  input wire logic [31:0] i_rdata,
  input wire logic [1:0] i_rresp,
  input wire logic i_rvalid,
  output logic o_rready
);
  int cyc = 0;
  int b_cyc = 0;
  always @(posedge i_clk) cyc <= cyc + 1;
  initial begin
    {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
    o_awaddr = 8'h00;
    o_araddr = 8'h00;
    o_wdata = 32'h00000000;
  end
  // released payload is inverted so a late sample never sees a stale match
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge i_clk);
    o_awaddr <= a;
    o_wdata <= d;
    {o_awvalid, o_wvalid, o_bready} <= 3'h7;
    do begin
      @(posedge i_clk);
      if (o_awvalid && i_awready) begin
        o_awvalid <= 1'b0;
        o_awaddr <= ~a;
      end
      if (o_wvalid && i_wready) begin
        o_wvalid <= 1'b0;
        o_wdata <= ~d;
      end
    end while (!i_bvalid);
    resp = i_bresp;
    b_cyc = cyc;
    o_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge i_clk);
    o_araddr <= a;
    {o_arvalid, o_rready} <= 2'h3;
    do begin
      @(posedge i_clk);
      if (o_arvalid && i_arready) begin
        o_arvalid <= 1'b0;
        o_araddr <= ~a;
      end
    end while (!i_rvalid);
    d = i_rdata;
    resp = i_rresp;
    o_rready <= 1'b0;
  endtask : rd
  // callers pass only defined length, type and latency codes
  task automatic load(input logic [1:0] ba, input logic [12:0] v);
    logic [1:0] r;
    wr(8'h08, {11'h000, v, 2'h0, ba, 4'h0}, r);
    repeat (2) @(posedge i_clk);
  endtask : load
  task automatic wait_lock(output bit ok);
    ok = 0;
    for (int i = 0; i < 60 && !ok; i++) begin
      @(posedge i_clk);
      ok = i_dll_locked;
    end
  endtask : wait_lock
endmodule : dbmc_ctl_model

// *** tb/test_ddr_burst_mode_config.sv ***
`timescale 1ns/1ps
module test_ddr_burst_mode_config;
  import dbmc_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  dbmc_resp_t bresp, rresp;
  logic [2:0] col_off;
  logic col_valid, col_write, col_last, launch, lfall, locked, half;
  int error_cnt = 0;
  int n_compared = 0;
  logic [2:0] beats[$];
  bit seen_last = 0;
  logic cw = 1'b0;
  int l_cyc = 0;
  logic l_fall = 1'b0;
  always #5 i_clk = ~i_clk;
  dbmc_top #(.LOCK_CYCLES(8)) dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(1'b1),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .o_col_offset(col_off), .o_col_valid(col_valid),
    .o_col_write(col_write), .o_col_last(col_last), .o_read_launch(launch),
    .o_launch_falling(lfall), .o_dll_locked(locked), .o_half_drive(half));
  dbmc_ctl_model u_ctl (.i_clk(i_clk), .i_dll_locked(locked), .o_awaddr(awaddr),
    .o_awvalid(awvalid), .i_awready(awready), .o_wdata(wdata), .o_wvalid(wvalid),
    .i_wready(wready), .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready),
    .o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata),
    .i_rresp(rresp), .i_rvalid(rvalid), .o_rready(rready));
  always @(posedge i_clk) begin
    if (col_valid === 1'b1) begin
      beats.push_back(col_off);
      cw = col_write;
    end
    if (col_last === 1'b1) seen_last = 1;
    if (launch === 1'b1) begin
      l_cyc = u_ctl.cyc;
      l_fall = lfall;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic burst(input logic [2:0] blc, input logic bt, input logic [2:0] st, input logic w);
    int n;
    logic [1:0] r;
    logic [31:0] sq;
    n = 1 << blc;
    u_ctl.load(2'b00, {6'h00, 3'h2, bt, blc});
    beats.delete();
    seen_last = 0;
    // high column bits set to show they never leak into the offset
    u_ctl.wr(8'h08, {6'h00, w, !w, 3'h0, 10'h0A8, st, 4'h0, w ? 4'h2 : 4'hA}, r);
    for (int i = 0; i < 40 && !seen_last; i++) @(posedge i_clk);
    chk("beat count", n, beats.size());
    for (int k = 0; k < n && k < beats.size(); k++) begin
      chk("beat offset", bt ? ((st & (n - 1)) ^ k) : ((st + k) & (n - 1)), beats[k]);
    end
    chk("col write", w, cw);
    u_ctl.rd(8'h10, sq, r);
    chk("start offset", st & (n - 1), sq[2:0]);
  endtask : burst
  task automatic cl_case(input logic [2:0] clc, input int m, input logic f);
    logic [1:0] r;
    u_ctl.load(2'b00, {6'h00, clc, 4'h3});
    l_cyc = -100;
    u_ctl.wr(8'h08, 32'h0100000A, r);
    repeat (20) @(posedge i_clk);
    chk("launch delay", m, l_cyc - u_ctl.b_cyc);
    chk("launch falling", f, l_fall);
  endtask : cl_case
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    bit ok;
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    u_ctl.rd(8'h00, d, r);
    chk("base reset", 32'h00000000, d);
    u_ctl.rd(8'h04, d, r);
    chk("ext reset", 32'h00000000, d);
    u_ctl.wr(8'h1C, 32'h00000000, r);
    chk("unmapped wr", 2, r);
    u_ctl.rd(8'h1C, d, r);
    chk("unmapped rd", 2, r);
    u_ctl.load(2'b01, 13'h0002);
    chk("half drive", 1, half);
    u_ctl.load(2'b00, 13'h0123);
    chk("lock dropped", 0, locked);
    u_ctl.wait_lock(ok);
    chk("lock", 1, ok);
    u_ctl.rd(8'h04, d, r);
    chk("ext kept", 32'h00000002, d);
    u_ctl.rd(8'h00, d, r);
    chk("base kept", 32'h00000123, d);
    for (int b = 1; b <= 3; b++) begin
      for (int t = 0; t < 2; t++) begin
        burst(3'(b), t[0], 3'h5, 1'b0);
      end
    end
    burst(3'h3, 1'b0, 3'h1, 1'b1);
    burst(3'h2, 1'b1, 3'h3, 1'b1);
    cl_case(3'h2, 2, 1'b0);
    cl_case(3'h3, 3, 1'b0);
    cl_case(3'h6, 2, 1'b1);
    u_ctl.wr(8'h08, 32'h04000008, r);
    u_ctl.rd(8'h0C, d, r);
    chk("self refresh", 1, d[3]);
    chk("dll off", 0, locked);
    u_ctl.wr(8'h08, 32'h08000008, r);
    u_ctl.wait_lock(ok);
    chk("relock", 1, ok);
    // debug period with the dll disabled, then the controller turns it back on
    u_ctl.load(2'b01, 13'h0003);
    chk("dll disabled", 0, locked);
    u_ctl.load(2'b01, 13'h0002);
    u_ctl.wait_lock(ok);
    chk("dll reenabled", 1, ok);
    u_ctl.load(2'b01, 13'h0000);
    chk("full drive", 0, half);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    test_done();
  end
endmodule : test_ddr_burst_mode_config
